// file: wrf_cfg.svh
// Constants for the windowed register file: widths, tag codes, depths.
// Assumes it is included by bare name from the package and modules.
`ifndef WRF_CFG_SVH
`define WRF_CFG_SVH

// ==========================================================================
// Word layout
// ==========================================================================
`define WRF_TAG_W        6
`define WRF_DATA_W       32
`define WRF_CDR_W        2
`define WRF_CDR_INTR_BIT 1
`define WRF_CDR_PRE_BIT  0
`define WRF_WORD_W       38
`define WRF_REG_NUM_W    5
`define WRF_SLOT_W       4
`define WRF_BUILD_BIT    4
`define WRF_WIN_SLOTS    16
`define WRF_WSP_W        4
`define WRF_STACK_WIN    16
`define WRF_STACK_DEPTH  256
`define WRF_STACK_IDX_W  8
`define WRF_WSP_RESET    4'h0
`define WRF_WSP_ONE      4'h1

// ==========================================================================
// Tag codes (octal 46, 47, 50..77)
// ==========================================================================
`define WRF_TAG_PC       6'h26
`define WRF_TAG_BRK      6'h27
`define WRF_TAG_INSN_LO  6'h28
`define WRF_TAG_INSN_HI  6'h3f

// ==========================================================================
// Cache line index: low six address bits, 64 lines
// ==========================================================================
`define WRF_LINE_W       6
`define WRF_ADDR_W       32
`define WRF_VTAG_W       26

`endif

// file: wrf_pkg.sv
// Types shared by the windowed register file and its tag decoder.
// Assumes wrf_cfg.svh is on the include path.
`default_nettype none
`include "wrf_cfg.svh"

package wrf_pkg;
  typedef enum logic [2:0]
  {
    TC_DATA,
    TC_PC,
    TC_BREAKPOINT,
    TC_INSTRUCTION
  } tag_class_t;

  typedef enum logic [1:0]
  {
    WIN_IDLE,
    WIN_CALL,
    WIN_RETURN
  } win_op_t;
endpackage
`default_nettype wire

// file: tag_decoder.sv
// Combinational tag decoder feeding the register file.
// Assumes the 6-bit tag arrives with the cdr code already stripped.
`timescale 1ns/10ps
`default_nettype none
`include "wrf_cfg.svh"

module tag_decoder
(
  input  wire logic [`WRF_TAG_W-1:0] tag_i,
  output var  wrf_pkg::tag_class_t   tag_class_o,
  output var  logic                  brk_trap_o
);
  import wrf_pkg::*;

  // ==========================================================================
  // Classification
  // ==========================================================================
  // Octal 46 is a pc, 47 a breakpoint trap, 50..77 one instruction type.
  always_comb
  begin
    brk_trap_o = 1'b0;
    if (tag_i == `WRF_TAG_PC)
      tag_class_o = TC_PC;
    else if (tag_i == `WRF_TAG_BRK)
    begin
      tag_class_o = TC_BREAKPOINT;
      brk_trap_o = 1'b1;
    end
    else if (tag_i >= `WRF_TAG_INSN_LO)
      tag_class_o = TC_INSTRUCTION;
    else
      tag_class_o = TC_DATA;
  end
endmodule
`default_nettype wire

// file: windowed_register_file.sv
// Overlapping window register file with tag classification, instruction
// word handling and a virtually indexed instruction cache line store.
// Assumes a single 125 MHz clock; operands and controls are synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "wrf_cfg.svh"

module windowed_register_file
(
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  input  wire logic [`WRF_REG_NUM_W-1:0] rd_num_a_i,
  input  wire logic [`WRF_REG_NUM_W-1:0] rd_num_b_i,
  input  wire logic                      wr_en_i,
  input  wire logic [`WRF_REG_NUM_W-1:0] wr_num_i,
  input  wire logic [`WRF_WORD_W-1:0]    wr_word_i,
  input  wire logic [`WRF_CDR_W-1:0]     wr_cdr_i,
  input  wire logic                      ext_sel_a_i,
  input  wire logic [`WRF_WORD_W-1:0]    ext_word_a_i,
  input  wire wrf_pkg::win_op_t          win_op_i,
  input  wire logic                      fetch_en_i,
  input  wire logic [`WRF_ADDR_W-1:0]    fetch_vaddr_i,
  input  wire logic [`WRF_WORD_W-1:0]    fetch_word_i,
  input  wire logic [`WRF_CDR_W-1:0]     fetch_cdr_i,
  input  wire logic                      fetch_double_i,
  input  wire logic                      mapped_ref_i,
  input  wire logic                      identity_mapped_i,
  input  wire logic                      map_hit_i,
  input  wire logic [`WRF_DATA_W-1:0]    pc_addr_i,
  output logic      [`WRF_WORD_W-1:0]    rd_word_a_o,
  output logic      [`WRF_WORD_W-1:0]    rd_word_b_o,
  output logic      [`WRF_WSP_W-1:0]     window_stack_pointer_o,
  output logic                           tag_is_pc_o,
  output logic                           tag_is_insn_o,
  output logic                           brk_trap_o,
  output logic                           icache_hit_o,
  output logic      [`WRF_WORD_W-1:0]    insn_word_o,
  output logic                           insn_double_o,
  output logic                           inhibit_intr_o,
  output logic                           inhibit_preempt_o,
  output logic                           map_miss_o,
  output logic      [`WRF_WORD_W-1:0]    pc_word_o
);
  import wrf_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Map a register number to a window stack slot, relative to the pointer.
  function automatic logic [`WRF_STACK_IDX_W-1:0] slot_index
  (
    input logic [`WRF_WSP_W-1:0]     window_stack_pointer,
    input logic [`WRF_REG_NUM_W-1:0] num
  );
    logic [`WRF_WSP_W-1:0] win;
    win = window_stack_pointer + {{(`WRF_WSP_W-1){1'b0}}, num[`WRF_BUILD_BIT]};
    slot_index = {win, num[`WRF_SLOT_W-1:0]};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  // The window stack is a ring of sixteen windows; spill handling is up to
  // software, so a deep call chain simply wraps and overwrites.
  logic [`WRF_WORD_W-1:0]   window_stack_reg [`WRF_STACK_DEPTH];
  logic [`WRF_WORD_W-1:0]   window_stack_next [`WRF_STACK_DEPTH];
  logic [`WRF_WSP_W-1:0]    wsp_reg;
  logic [`WRF_WSP_W-1:0]    wsp_next;
  logic [`WRF_VTAG_W-1:0]   icache_vtag_reg [1<<`WRF_LINE_W];
  logic [`WRF_VTAG_W-1:0]   icache_vtag_next [1<<`WRF_LINE_W];
  logic [(1<<`WRF_LINE_W)-1:0] icache_val_reg;
  logic [(1<<`WRF_LINE_W)-1:0] icache_val_next;
  logic [`WRF_WORD_W-1:0]   rd_a_reg;
  logic [`WRF_WORD_W-1:0]   rd_a_next;
  logic [`WRF_WORD_W-1:0]   rd_b_reg;
  logic [`WRF_WORD_W-1:0]   rd_b_next;
  logic                     is_pc_reg;
  logic                     is_pc_next;
  logic                     is_insn_reg;
  logic                     is_insn_next;
  logic                     brk_reg;
  logic                     brk_next;
  logic                     hit_reg;
  logic                     hit_next;
  logic [`WRF_WORD_W-1:0]   insn_reg;
  logic [`WRF_WORD_W-1:0]   insn_next;
  logic                     dbl_reg;
  logic                     dbl_next;
  logic                     inh_i_reg;
  logic                     inh_i_next;
  logic                     inh_p_reg;
  logic                     inh_p_next;
  logic                     miss_reg;
  logic                     miss_next;
  logic [`WRF_WORD_W-1:0]   pc_reg;
  logic [`WRF_WORD_W-1:0]   pc_next;
  tag_class_t               fetch_class;
  logic                     fetch_brk;

  // Classify the tag of the fetched word.
  tag_decoder u_tag_decoder
  (
    .tag_i       (fetch_word_i[`WRF_WORD_W-1:`WRF_DATA_W]),
    .tag_class_o (fetch_class),
    .brk_trap_o  (fetch_brk)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Reads see the pre-write contents; a same-cycle write shows next cycle.
  always_comb
  begin
    logic [`WRF_LINE_W-1:0] line;
    line = fetch_vaddr_i[`WRF_LINE_W-1:0];
    window_stack_next = window_stack_reg;
    wsp_next = wsp_reg;
    icache_vtag_next = icache_vtag_reg;
    icache_val_next = icache_val_reg;
    // Two read ports over the 32 visible slots; port A can take an external operand instead.
    rd_a_next = ext_sel_a_i ? ext_word_a_i
              : window_stack_reg[slot_index(wsp_reg, rd_num_a_i)];
    rd_b_next = window_stack_reg[slot_index(wsp_reg, rd_num_b_i)];
    // The cdr input is deliberately ignored: the slots have no room for it.
    if (wr_en_i)
      window_stack_next[slot_index(wsp_reg, wr_num_i)] = wr_word_i;
    // Old build window becomes the current window on call, reversed on
    // return; build contents are never copied, only re-addressed.
    case (win_op_i)
      WIN_CALL:   wsp_next = wsp_reg + `WRF_WSP_ONE;
      WIN_RETURN: wsp_next = wsp_reg - `WRF_WSP_ONE;
      default:    wsp_next = wsp_reg;
    endcase
    is_pc_next = fetch_en_i && (fetch_class == TC_PC);
    is_insn_next = fetch_en_i && (fetch_class == TC_INSTRUCTION);
    brk_next = fetch_en_i && fetch_brk;
    hit_next = 1'b0;
    insn_next = insn_reg;
    dbl_next = dbl_reg;
    inh_i_next = inh_i_reg;
    inh_p_next = inh_p_reg;
    if (fetch_en_i)
    begin
      hit_next = icache_val_reg[line] && (icache_vtag_reg[line] ==
                 fetch_vaddr_i[`WRF_ADDR_W-1:`WRF_LINE_W]);
      // Executing any word on the line retags it, so a stale entry is gone.
      icache_vtag_next[line] = fetch_vaddr_i[`WRF_ADDR_W-1:`WRF_LINE_W];
      icache_val_next[line] = 1'b1;
      insn_next = fetch_word_i;
      dbl_next = fetch_double_i;
      inh_i_next = fetch_cdr_i[`WRF_CDR_INTR_BIT];
      inh_p_next = fetch_cdr_i[`WRF_CDR_PRE_BIT];
    end
    miss_next = mapped_ref_i && !identity_mapped_i && !map_hit_i;
    pc_next = {`WRF_TAG_PC, pc_addr_i};
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Storage arrays carry no reset; only control and outputs are cleared.
  always_ff @(posedge sys_clk_i)
  begin
    window_stack_reg <= window_stack_next;
    icache_vtag_reg <= icache_vtag_next;
    if (srst_i)
    begin
      wsp_reg <= `WRF_WSP_RESET;
      icache_val_reg <= '0;
      rd_a_reg <= '0;
      rd_b_reg <= '0;
      is_pc_reg <= 1'b0;
      is_insn_reg <= 1'b0;
      brk_reg <= 1'b0;
      hit_reg <= 1'b0;
      insn_reg <= '0;
      dbl_reg <= 1'b0;
      inh_i_reg <= 1'b0;
      inh_p_reg <= 1'b0;
      miss_reg <= 1'b0;
      pc_reg <= '0;
    end
    else
    begin
      wsp_reg <= wsp_next;
      icache_val_reg <= icache_val_next;
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
      is_pc_reg <= is_pc_next;
      is_insn_reg <= is_insn_next;
      brk_reg <= brk_next;
      hit_reg <= hit_next;
      insn_reg <= insn_next;
      dbl_reg <= dbl_next;
      inh_i_reg <= inh_i_next;
      inh_p_reg <= inh_p_next;
      miss_reg <= miss_next;
      pc_reg <= pc_next;
    end
  end

  // Outputs come straight from flip-flops.
  assign rd_word_a_o = rd_a_reg;
  assign rd_word_b_o = rd_b_reg;
  assign window_stack_pointer_o = wsp_reg;
  assign tag_is_pc_o = is_pc_reg;
  assign tag_is_insn_o = is_insn_reg;
  assign brk_trap_o = brk_reg;
  assign icache_hit_o = hit_reg;
  assign insn_word_o = insn_reg;
  assign insn_double_o = dbl_reg;
  assign inhibit_intr_o = inh_i_reg;
  assign inhibit_preempt_o = inh_p_reg;
  assign map_miss_o = miss_reg;
  assign pc_word_o = pc_reg;
endmodule
`default_nettype wire

// file: wrf_properties.sv
// Checker for the windowed register file, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "wrf_cfg.svh"
module wrf_check
(
  input wire logic                   sys_clk_i,
  input wire logic                   srst_i,
  input wire wrf_pkg::win_op_t       win_op_i,
  input wire logic                   fetch_en_i,
  input wire logic [31:0]            fetch_vaddr_i,
  input wire logic [37:0]            fetch_word_i,
  input wire logic [1:0]             fetch_cdr_i,
  input wire logic                   mapped_ref_i,
  input wire logic                   identity_mapped_i,
  input wire logic                   map_hit_i,
  input wire logic [31:0]            pc_addr_i,
  input wire logic [3:0]             window_stack_pointer_o,
  input wire logic                   tag_is_pc_o,
  input wire logic                   tag_is_insn_o,
  input wire logic                   brk_trap_o,
  input wire logic                   icache_hit_o,
  input wire logic                   inhibit_intr_o,
  input wire logic                   inhibit_preempt_o,
  input wire logic                   map_miss_o,
  input wire logic [37:0]            pc_word_o
);
  import wrf_pkg::*;
  // ====
  // Helpers; $past is given whole signals only, so slices live here.
  wire logic [5:0] ftag = fetch_word_i[37:32];
  wire logic       miss_c = mapped_ref_i & ~identity_mapped_i & ~map_hit_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_pc_tag_word: assert property (!$past(srst_i) |->
    pc_word_o == {`WRF_TAG_PC, $past(pc_addr_i)}) else $error("pc tag");
  a_map_miss_cond: assert property (!$past(srst_i) |->
    map_miss_o == $past(miss_c)) else $error("map miss");
  a_call_advance: assert property (win_op_i == WIN_CALL |=>
    window_stack_pointer_o == $past(window_stack_pointer_o) + `WRF_WSP_ONE)
    else $error("call shift");
  a_return_retreat: assert property (win_op_i == WIN_RETURN |=>
    window_stack_pointer_o == $past(window_stack_pointer_o) - `WRF_WSP_ONE)
    else $error("return shift");
  a_idle_wsp_held: assert property (win_op_i == WIN_IDLE |=>
    $stable(window_stack_pointer_o)) else $error("wsp moved");
  a_brk_trap_tag: assert property (fetch_en_i && ftag == `WRF_TAG_BRK
    |=> brk_trap_o && !tag_is_pc_o && !tag_is_insn_o) else $error("brk");
  a_pc_class_tag: assert property (fetch_en_i && ftag == `WRF_TAG_PC
    |=> tag_is_pc_o && !brk_trap_o) else $error("pc class");
  a_insn_tag_range: assert property (fetch_en_i |=>
    tag_is_insn_o == ($past(ftag) >= `WRF_TAG_INSN_LO)) else $error("insn");
  a_cdr_inhibit_map: assert property (fetch_en_i |=>
    {inhibit_intr_o, inhibit_preempt_o} == $past(fetch_cdr_i))
    else $error("inhibit");
  a_refetch_line_hit: assert property (fetch_en_i ##1
    (fetch_en_i && $stable(fetch_vaddr_i)) |=> icache_hit_o)
    else $error("refetch");
  c_call: cover property (win_op_i == WIN_CALL);
  c_trap: cover property (brk_trap_o);
  c_hit: cover property (icache_hit_o);
endmodule
bind windowed_register_file wrf_check chk (.sys_clk_i(sys_clk_i),
  .srst_i(srst_i), .win_op_i(win_op_i), .fetch_en_i(fetch_en_i),
  .fetch_vaddr_i(fetch_vaddr_i), .fetch_word_i(fetch_word_i),
  .fetch_cdr_i(fetch_cdr_i), .mapped_ref_i(mapped_ref_i),
  .identity_mapped_i(identity_mapped_i), .map_hit_i(map_hit_i),
  .pc_addr_i(pc_addr_i), .window_stack_pointer_o(window_stack_pointer_o),
  .tag_is_pc_o(tag_is_pc_o), .tag_is_insn_o(tag_is_insn_o),
  .brk_trap_o(brk_trap_o), .icache_hit_o(icache_hit_o),
  .inhibit_intr_o(inhibit_intr_o), .inhibit_preempt_o(inhibit_preempt_o),
  .map_miss_o(map_miss_o), .pc_word_o(pc_word_o));
`default_nettype wire

// file: tb_top.sv
// Random self-checking bench for the windowed register file.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "wrf_cfg.svh"
module tb_top;
  import wrf_pkg::*;
  logic        sys_clk_i = 0, srst_i = 1, wr_en_i = 0, ext_sel_a_i = 0;
  logic        fetch_en_i = 0, fetch_double_i = 0, mapped_ref_i = 0;
  logic        identity_mapped_i = 0, map_hit_i = 0, armed = 0;
  logic [4:0]  rd_num_a_i = 0, rd_num_b_i = 0, wr_num_i = 0;
  logic [1:0]  wr_cdr_i = 0, fetch_cdr_i = 0, e_cdr;
  logic [37:0] wr_word_i = 0, ext_word_a_i = 0, fetch_word_i = 0;
  logic [31:0] fetch_vaddr_i = 0, pc_addr_i = 0, seed = 32'h38f94c55;
  win_op_t     win_op_i = WIN_IDLE;
  logic [37:0] rd_word_a_o, rd_word_b_o, insn_word_o, pc_word_o;
  logic [37:0] e_a, e_b, e_pc, e_iw, mem [256];
  logic [3:0]  window_stack_pointer_o, window_stack_pointer;
  logic        tag_is_pc_o, tag_is_insn_o, brk_trap_o, icache_hit_o;
  logic        insn_double_o, inhibit_intr_o, inhibit_preempt_o, map_miss_o;
  logic        e_miss, e_hit, e_brk, e_ispc, e_ins, e_dbl;
  logic [63:0] vld;
  logic [25:0] vtg [64];
  logic [5:0]  t, ln;
  int          num_errors = 0, num_checks = 0, cycles = 0;
  windowed_register_file dut (.sys_clk_i, .srst_i, .rd_num_a_i, .rd_num_b_i,
    .wr_en_i, .wr_num_i, .wr_word_i, .wr_cdr_i, .ext_sel_a_i, .ext_word_a_i,
    .win_op_i, .fetch_en_i, .fetch_vaddr_i, .fetch_word_i, .fetch_cdr_i,
    .fetch_double_i, .mapped_ref_i, .identity_mapped_i, .map_hit_i,
    .pc_addr_i, .rd_word_a_o, .rd_word_b_o, .window_stack_pointer_o,
    .tag_is_pc_o, .tag_is_insn_o, .brk_trap_o, .icache_hit_o, .insn_word_o,
    .insn_double_o, .inhibit_intr_o, .inhibit_preempt_o, .map_miss_o,
    .pc_word_o);
  always #4 sys_clk_i = ~sys_clk_i;
  // ====
  // Helpers: random source, slot index, comparison and verdict.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] idx(logic [3:0] w, logic [4:0] n);
    return {w + {3'h0, n[4]}, n[3:0]};
  endfunction
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Mode 0 random, 1 tag sweep on one line, 2 write build slot and call,
  // 3 read current slot 0 with the window held.
  task automatic step(int mode, logic [5:0] k);
    logic [31:0] r, q;
    r = xs();
    q = xs();
    if (mode == 1) {r[20], q[12:6], r[5:0]} = {2'h2, k, 6'h0};
    if (mode == 2) {r[19:15], r[14:10]} = {5'h9, 5'h10};
    if (mode == 3) {r[19:15], r[4:0]} = 10'h0;
    @(posedge sys_clk_i);
    {rd_num_b_i, rd_num_a_i} <= r[9:0];
    {wr_en_i, wr_num_i} <= r[15:10];
    ext_sel_a_i <= r[16] & r[17];
    win_op_i <= win_op_t'(r[19:18] == 2'h3 ? 2'h0 : r[19:18]);
    {fetch_cdr_i, fetch_double_i, fetch_en_i} <= r[23:20];
    {map_hit_i, identity_mapped_i, mapped_ref_i} <= r[26:24];
    fetch_vaddr_i <= {25'h0, q[12], r[5:0]};
    fetch_word_i <= {q[11:6], r};
    {wr_cdr_i, wr_word_i} <= {q[14:13], q[5:0], r ^ q};
    ext_word_a_i <= {q[5:0], ~r};
    pc_addr_i <= q;
  endtask
  // Reference model, updated on the same edge the design samples.
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (srst_i)
    begin
      {e_a, e_b, e_pc, e_iw, e_miss, e_hit, e_brk, e_ispc} = '0;
      {e_ins, e_dbl, e_cdr, window_stack_pointer, vld} = '0;
    end
    else
    begin
      e_a = ext_sel_a_i ? ext_word_a_i : mem[idx(window_stack_pointer, rd_num_a_i)];
      e_b = mem[idx(window_stack_pointer, rd_num_b_i)];
      if (wr_en_i) mem[idx(window_stack_pointer, wr_num_i)] = wr_word_i;
      e_pc = {`WRF_TAG_PC, pc_addr_i};
      e_miss = mapped_ref_i & ~identity_mapped_i & ~map_hit_i;
      t = fetch_word_i[37:32];
      ln = fetch_vaddr_i[5:0];
      e_ispc = fetch_en_i & (t == `WRF_TAG_PC);
      e_brk = fetch_en_i & (t == `WRF_TAG_BRK);
      e_ins = fetch_en_i & (t >= `WRF_TAG_INSN_LO);
      e_hit = fetch_en_i & vld[ln] & (vtg[ln] == fetch_vaddr_i[31:6]);
      if (fetch_en_i)
        {vld[ln], vtg[ln], e_iw, e_dbl, e_cdr} =
          {1'b1, fetch_vaddr_i[31:6], fetch_word_i, fetch_double_i,
           fetch_cdr_i};
      if (win_op_i == WIN_CALL) window_stack_pointer++;
      else if (win_op_i == WIN_RETURN) window_stack_pointer--;
    end
  end
  // Outputs are settled by the falling edge; unwritten slots are skipped.
  always @(negedge sys_clk_i)
    if (armed)
    begin
      if (!$isunknown(e_a)) check("rd_a", rd_word_a_o, e_a);
      if (!$isunknown(e_b)) check("rd_b", rd_word_b_o, e_b);
      check("wsp", window_stack_pointer_o, window_stack_pointer);
      check("pc", pc_word_o, e_pc);
      check("miss", map_miss_o, e_miss);
      check("cls", {tag_is_pc_o, brk_trap_o}, {e_ispc, e_brk});
      check("insn", tag_is_insn_o, e_ins);
      check("hit", icache_hit_o, e_hit);
      check("dbl", {insn_double_o, insn_word_o}, {e_dbl, e_iw});
      check("cdr", {inhibit_intr_o, inhibit_preempt_o}, e_cdr);
    end
  // A hang is cut short well past the expected 4106 cycles.
  always @(posedge sys_clk_i)
    if (cycles == 10000)
    begin
      num_errors++;
      give_verdict();
    end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    armed = 1'b1;
    repeat (4000) step(0, 6'h0);
    for (int k = 0; k < 64; k++) step(1, 6'(k));
    repeat (4)
    begin
      step(2, 6'h0);
      step(3, 6'h0);
    end
    repeat (20) step(0, 6'h0);
    repeat (2) @(posedge sys_clk_i);
    give_verdict();
  end
endmodule
`default_nettype wire
